// >>> sim/core_model.sv
// processor core as seen by the interrupt block: takes, serves and returns from handlers
`timescale 1ns/100ps
module core_model
(
	input wire logic clk,
	input wire logic rst_n,
	input wire nested_irq_pkg::core_req_s core_req,
	input wire logic nmi_req,
	input wire logic [7:0] lat,
	input wire logic [7:0] hold,
	output nested_irq_pkg::core_cmd_s core_cmd
);
	import nested_irq_pkg::*;
	// ****
	// handler sequencing
	// ****
	// one handler at a time: no nesting, so preemption is left untested
	logic busy;
	logic in_h;
	logic [7:0] cnt;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			core_cmd <= '0;
			busy <= 1'b0;
			in_h <= 1'b0;
			cnt <= 8'h00;
		end
		else
		begin
			core_cmd.entry <= 1'b0;
			core_cmd.exit <= 1'b0;
			core_cmd.nmi_ack <= nmi_req && !core_cmd.nmi_ack;
			if (!busy)
			begin
				busy <= core_req.valid;
				in_h <= 1'b0;
				cnt <= lat;
			end
			else if (cnt != 8'h00)
				cnt <= cnt - 8'h01;
			else if (!in_h)
			begin
				// late arrival wins: id taken at the entry edge
				core_cmd.entry <= core_req.valid;
				core_cmd.id <= core_req.id;
				in_h <= core_req.valid;
				busy <= core_req.valid;
				cnt <= hold;
			end
			else
			begin
				core_cmd.exit <= 1'b1;
				busy <= 1'b0;
			end
		end
	end
endmodule

// >>> sim/irq_enable_pending_checker.sv
// assertions on the ports of the interrupt enable and pending block
`timescale 1ns/100ps
`include "nested_irq_regs.svh"
module irq_enable_pending_checker
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`NUM_IRQ-1:0] irq_in,
	input wire logic nmi_in,
	input wire nested_irq_pkg::axi_in_s axi_in,
	input wire nested_irq_pkg::axi_out_s axi_out,
	input wire nested_irq_pkg::core_cmd_s core_cmd,
	input wire nested_irq_pkg::core_req_s core_req,
	input wire logic nmi_req
);
	import nested_irq_pkg::*;
	// ****
	// properties
	// ****
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	property p_b_once;
		axi_out.bvalid && axi_in.bready |=> !axi_out.bvalid;
	endproperty
	a_b_once: assert property (p_b_once) else $error("write response repeated");
	property p_r_once;
		axi_out.rvalid && axi_in.rready |=> !axi_out.rvalid && !axi_out.arready;
	endproperty
	a_r_once: assert property (p_r_once) else $error("read response repeated");
	property p_b_lat;
		axi_in.awvalid && axi_out.awready && axi_in.wvalid && axi_out.wready |-> ##2 axi_out.bvalid;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("write response late");
	property p_r_lat;
		axi_in.arvalid && axi_out.arready |=> axi_out.rvalid && !axi_out.arready;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read response late");
	property p_aw_refuse;
		axi_in.awvalid && axi_out.awready |=> !axi_out.awready [*2];
	endproperty
	a_aw_refuse: assert property (p_aw_refuse) else $error("second write taken early");
	property p_unmapped;
		axi_in.arvalid && axi_out.arready && axi_in.araddr >= 32'h0000_1000
			|=> axi_out.rresp == `RESP_SLVERR && axi_out.rdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	property p_entry_drop;
		core_cmd.entry |=> !core_req.valid;
	endproperty
	a_entry_drop: assert property (p_entry_drop) else $error("request kept after entry");
	property p_nmi_lat;
		$rose(nmi_in) |-> ##[1:6] nmi_req;
	endproperty
	a_nmi_lat: assert property (p_nmi_lat) else $error("non-maskable request missed");
	property p_req_id;
		core_req.valid |-> core_req.id < `NUM_IRQ;
	endproperty
	a_req_id: assert property (p_req_id) else $error("request for absent interrupt");
	property p_reset_quiet;
		$rose(rst_n) |-> !core_req.valid && !nmi_req && !axi_out.bvalid && !axi_out.rvalid;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
	c_entry: cover property (core_cmd.entry && core_cmd.id == 7'h28);
	c_nmi: cover property ($rose(nmi_req));
	c_slverr: cover property (axi_out.rvalid && axi_out.rresp == `RESP_SLVERR);
endmodule
bind irq_enable_pending_control irq_enable_pending_checker irq_enable_pending_checker_i (.clk(clk), .rst_n(rst_n),
	.irq_in(irq_in), .nmi_in(nmi_in), .axi_in(axi_in), .axi_out(axi_out), .core_cmd(core_cmd),
	.core_req(core_req), .nmi_req(nmi_req));

// >>> sim/test_irq_enable_pending_control.sv
// self-checking bench for the interrupt enable and pending block
`timescale 1ns/100ps
`include "nested_irq_regs.svh"
module test_irq_enable_pending_control;
	import nested_irq_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [`NUM_IRQ-1:0] irq_in;
	logic nmi_in;
	axi_in_s axi_in;
	axi_out_s axi_out;
	core_cmd_s core_cmd;
	core_req_s core_req;
	logic nmi_req;
	logic [7:0] lat;
	logic [7:0] hold;
	logic [95:0] impl;
	logic [31:0] d;
	logic [31:0] en;
	logic [33:0] q_r[$];
	logic [33:0] q_b[$];
	logic [33:0] q_id[$];
	int fails;
	int n_tests;
	int seed;
	int k;
	irq_enable_pending_control irq_enable_pending_control_i (.clk(clk), .rst_n(rst_n), .irq_in(irq_in),
		.nmi_in(nmi_in), .axi_in(axi_in), .axi_out(axi_out), .core_cmd(core_cmd), .core_req(core_req),
		.nmi_req(nmi_req));
	core_model core_model_i (.clk(clk), .rst_n(rst_n), .core_req(core_req), .nmi_req(nmi_req), .lat(lat),
		.hold(hold), .core_cmd(core_cmd));
	always #2.5 clk = ~clk;
	// ****
	// checking
	// ****
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		if (axi_out.rvalid === 1'b1 && axi_in.rready === 1'b1)
			chk({axi_out.rresp, axi_out.rdata}, q_r.pop_front());
		if (axi_out.bvalid === 1'b1 && axi_in.bready === 1'b1)
			chk({32'h0000_0000, axi_out.bresp}, q_b.pop_front());
		if (core_cmd.entry === 1'b1)
			chk({27'h0, core_cmd.id}, (q_id.size() == 0) ? 34'h3_FFFF_FFFF : q_id.pop_front());
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		summarize();
	end
	// ****
	// bus cycles
	// ****
	task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r = `RESP_OKAY);
		logic ta;
		logic tw;
		q_b.push_back({32'h0000_0000, r});
		ta = 1'b0;
		tw = 1'b0;
		@(posedge clk);
		axi_in.awvalid <= 1'b1;
		axi_in.awaddr <= a;
		axi_in.wvalid <= 1'b1;
		axi_in.wdata <= v;
		axi_in.bready <= 1'b1;
		while (!(ta && tw))
		begin
			@(posedge clk);
			if (axi_out.awready === 1'b1)
				ta = 1'b1;
			if (axi_out.wready === 1'b1)
				tw = 1'b1;
			if (ta)
				axi_in.awvalid <= 1'b0;
			if (tw)
				axi_in.wvalid <= 1'b0;
		end
		do @(posedge clk); while (axi_out.bvalid !== 1'b1);
		axi_in.bready <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r = `RESP_OKAY);
		q_r.push_back({r, v});
		@(posedge clk);
		axi_in.arvalid <= 1'b1;
		axi_in.araddr <= a;
		axi_in.rready <= 1'b1;
		do @(posedge clk); while (axi_out.arready !== 1'b1);
		axi_in.arvalid <= 1'b0;
		do @(posedge clk); while (axi_out.rvalid !== 1'b1);
		axi_in.rready <= 1'b0;
	endtask
	task automatic drain(input int post);
		int n;
		n = 0;
		while (q_id.size() != 0 && n < 2000)
		begin
			@(posedge clk);
			n++;
		end
		repeat (post) @(posedge clk);
	endtask
	// ****
	// scenarios
	// ****
	initial
	begin
		seed = 63149;
		fails = 0;
		n_tests = 0;
		impl = `IMPL_MASK;
		lat = 8'h02;
		hold = 8'h1E;
		irq_in = '0;
		nmi_in = 1'b0;
		axi_in = '0;
		axi_in.wstrb = 4'hF;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		for (k = 0; k < 3; k++)
		begin
			rd(32'(4 * k), 32'h0000_0000);
			rd(32'h0000_0080 + 32'(4 * k), 32'h0000_0000);
			rd(32'h0000_0100 + 32'(4 * k), 32'h0000_0000);
		end
		// random enables: no request is high, so nothing may be entered
		for (k = 0; k < 3; k++)
		begin
			d = $random(seed);
			en = d & impl[32 * k +: 32];
			wr(32'(4 * k), d);
			rd(32'(4 * k), en);
			rd(32'h0000_0080 + 32'(4 * k), en);
			d = $random(seed);
			wr(32'h0000_0080 + 32'(4 * k), d);
			rd(32'(4 * k), en & ~d);
			wr(32'h0000_0080 + 32'(4 * k), 32'hFFFF_FFFF);
		end
		for (k = 0; k < 3; k++)
		begin
			d = $random(seed);
			en = d & impl[32 * k +: 32];
			wr(32'h0000_0100 + 32'(4 * k), d);
			rd(32'h0000_0100 + 32'(4 * k), en);
			wr(32'h0000_0100 + 32'(4 * k), en);
			rd(32'h0000_0100 + 32'(4 * k), en);
			wr(32'h0000_0180 + 32'(4 * k), 32'hFFFF_FFFF);
			rd(32'h0000_0100 + 32'(4 * k), 32'h0000_0000);
		end
		rd(32'h0000_0800, 32'h0000_0000, `RESP_SLVERR);
		wr(32'h0000_1000, 32'h0000_0005, `RESP_SLVERR);
		wr(32'h0000_0400, 32'h0000_0007);
		rd(32'h0000_0400, 32'h0000_0004);
		wr(32'h0000_0400, 32'h0000_0000);
		wr(32'h0000_0320, 32'h0000_6000);
		wr(32'h0000_0328, 32'h0000_0030);
		wr(32'h0000_0330, 32'h0040_0000);
		rd(32'h0000_0328, 32'h0000_0030);
		wr(32'h0000_0004, 32'h0004_0102);
		rd(32'h0000_1004, 32'h0000_0000, `RESP_SLVERR);
		q_id = '{34'd40, 34'd33, 34'd50};
		wr(32'h0000_0104, 32'h0004_0102);
		// demoted one cycle before the first handler is entered, so it must come last
		wr(32'h0000_0330, 32'h0070_0000);
		drain(60);
		rd(32'h0000_0104, 32'h0000_0000);
		rd(32'h0000_0204, 32'h0000_0000);
		lat <= 8'h00;
		wr(32'h0000_0000, 32'h0000_0060);
		q_id = '{34'd5, 34'd5};
		irq_in[5] <= 1'b1;
		drain(1);
		irq_in[5] <= 1'b0;
		drain(60);
		q_id.push_back(34'd6);
		irq_in[6] <= 1'b1;
		@(posedge clk);
		irq_in[6] <= 1'b0;
		drain(60);
		irq_in[9] <= 1'b1;
		@(posedge clk);
		irq_in[9] <= 1'b0;
		repeat (8) @(posedge clk);
		rd(32'h0000_0100, 32'h0000_0200);
		wr(32'h0000_0180, 32'h0000_0200);
		rd(32'h0000_0100, 32'h0000_0000);
		@(posedge clk);
		nmi_in <= 1'b1;
		repeat (2) @(posedge clk);
		nmi_in <= 1'b0;
		k = 0;
		while (nmi_req !== 1'b1 && k < 20)
		begin
			@(posedge clk);
			k++;
		end
		chk({33'h0, nmi_req}, 34'h1);
		repeat (4) @(posedge clk);
		chk({33'h0, nmi_req}, 34'h0);
		chk(34'(q_id.size()), 34'h0);
		summarize();
	end
endmodule

// >>> src/irq_enable_pending_control.sv
// enable, pending and active state with arbitration for the nested interrupt controller
`timescale 1ns/100ps
`include "nested_irq_regs.svh"

module irq_enable_pending_control
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`NUM_IRQ-1:0] irq_in,
	input wire logic nmi_in,
	input wire nested_irq_pkg::axi_in_s axi_in,
	output nested_irq_pkg::axi_out_s axi_out,
	input wire nested_irq_pkg::core_cmd_s core_cmd,
	output nested_irq_pkg::core_req_s core_req,
	output logic nmi_req
);
	import nested_irq_pkg::*;

	// ****************************************
	// helpers
	// ****************************************

	// byte enables widened to a bit mask
	function automatic logic [31:0] strb_mask(input logic [3:0] strb);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int b = 0; b < 4; b++)
		begin
			m[b*8 +: 8] = {8{strb[b]}};
		end
		return m;
	endfunction

	// one-hot vector for an interrupt number, zero when not implemented
	function automatic logic [`BANK_BITS-1:0] id_onehot(input irq_id_t id);
		logic [`BANK_BITS-1:0] v;
		v = `BANK_BITS'(1) << id;
		return v & `IMPL_MASK;
	endfunction

	// group part of a priority: the low sub_bits are subpriority
	function automatic prio_t group_of(input prio_t p, input logic [2:0] sub_bits);
		return prio_t'(p >> sub_bits);
	endfunction

	// ****************************************
	// state
	// ****************************************

	logic [`BANK_BITS-1:0] enable;
	logic [`BANK_BITS-1:0] pending;
	logic [`BANK_BITS-1:0] active;
	prio_t prio [0:`NUM_IRQ-1];
	logic [2:0] sub_bits;
	logic [`NUM_IRQ-1:0] irq_meta;
	logic [`NUM_IRQ-1:0] irq_sync;
	logic [`NUM_IRQ-1:0] irq_prev;
	logic [2:0] nmi_sync;
	logic nmi_pending;

	logic aw_full;
	logic w_full;
	logic [9:0] wr_index;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;

	logic [`BANK_BITS-1:0] sw_enable_set;
	logic [`BANK_BITS-1:0] sw_enable_clear;
	logic [`BANK_BITS-1:0] sw_pending_set;
	logic [`BANK_BITS-1:0] sw_pending_clear;
	logic [`NUM_IRQ-1:0] prio_we;
	logic [`NUM_IRQ-1:0] prio_wsel;
	logic control_we;
	logic wr_mapped;
	logic do_write;

	logic [`BANK_BITS-1:0] entry_mask;
	logic [`BANK_BITS-1:0] exit_mask;
	logic [`BANK_BITS-1:0] hw_set;
	logic [`BANK_BITS-1:0] next_pending;
	logic [`BANK_BITS-1:0] next_active;
	logic [`BANK_BITS-1:0] in_level;
	logic [`BANK_BITS-1:0] in_rise;

	logic best_found;
	irq_id_t best_id;
	prio_t best_prio;
	logic any_active;
	prio_t run_group;
	logic preempt;

	logic [31:0] rd_word;
	logic rd_mapped;

	// ****************************************
	// input synchronisers and edge detection
	// ****************************************

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_meta <= '0;
			irq_sync <= '0;
			irq_prev <= '0;
		end
		else
		begin
			irq_meta <= irq_in;
			irq_sync <= irq_meta;
			irq_prev <= irq_sync;
		end
	end

	// pulses shorter than a clock may be missed; sources hold one cycle at least
	assign in_level = `BANK_BITS'(irq_sync);
	assign in_rise = `BANK_BITS'(irq_sync & ~irq_prev);

	// ****************************************
	// non-maskable input
	// ****************************************

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nmi_sync <= 3'h0;
			nmi_pending <= 1'b0;
		end
		else
		begin
			nmi_sync <= {nmi_sync[1:0], nmi_in};
			// a new edge wins over an acknowledge in the same cycle
			if (nmi_sync[1] && !nmi_sync[2])
				nmi_pending <= 1'b1;
			else if (core_cmd.nmi_ack)
				nmi_pending <= 1'b0;
		end
	end

	// ****************************************
	// register bus write decode
	// ****************************************

	always_comb
	begin
		sw_enable_set = '0;
		sw_enable_clear = '0;
		sw_pending_set = '0;
		sw_pending_clear = '0;
		prio_wsel = '0;
		control_we = 1'b0;
		wr_mapped = 1'b0;
		for (int k = 0; k < `NUM_WORDS; k++)
		begin
			if (wr_index == `ENABLE_SET_BASE + 10'(k))
			begin
				sw_enable_set[k*32 +: 32] = wr_data & strb_mask(wr_strb);
				wr_mapped = 1'b1;
			end
			if (wr_index == `ENABLE_CLEAR_BASE + 10'(k))
			begin
				sw_enable_clear[k*32 +: 32] = wr_data & strb_mask(wr_strb);
				wr_mapped = 1'b1;
			end
			if (wr_index == `PENDING_SET_BASE + 10'(k))
			begin
				sw_pending_set[k*32 +: 32] = wr_data & strb_mask(wr_strb);
				wr_mapped = 1'b1;
			end
			if (wr_index == `PENDING_CLEAR_BASE + 10'(k))
			begin
				sw_pending_clear[k*32 +: 32] = wr_data & strb_mask(wr_strb);
				wr_mapped = 1'b1;
			end
			if (wr_index == `ACTIVE_FLAG_BASE + 10'(k))
				wr_mapped = 1'b1;
		end
		for (int n = 0; n < `NUM_IRQ; n++)
		begin
			if (wr_index == `PRIORITY_BASE + 10'(n / 4) && wr_strb[n % 4])
				prio_wsel[n] = 1'b1;
		end
		if (wr_index >= `PRIORITY_BASE && wr_index < `PRIORITY_BASE + 10'(`NUM_PRIO_WORDS))
			wr_mapped = 1'b1;
		if (wr_index == `CONTROL_WORD)
		begin
			control_we = wr_strb[0];
			wr_mapped = 1'b1;
		end
		if (wr_index == `STATUS_WORD)
			wr_mapped = 1'b1;
	end

	assign do_write = aw_full && w_full && !axi_out.bvalid;
	assign prio_we = do_write ? prio_wsel : '0;

	// ****************************************
	// enable bank
	// ****************************************

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			enable <= `BANK_RESET;
		else if (do_write)
			enable <= ((enable & ~sw_enable_clear) | sw_enable_set) & `IMPL_MASK;
	end

	// ****************************************
	// priorities and grouping
	// ****************************************

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int n = 0; n < `NUM_IRQ; n++)
				prio[n] <= 4'h0;
		end
		else
		begin
			// only the top nibble of each byte is kept
			for (int n = 0; n < `NUM_IRQ; n++)
				if (prio_we[n])
					prio[n] <= wr_data[(n % 4)*8 + 4 +: 4];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sub_bits <= `CONTROL_RESET;
		else if (do_write && control_we)
			sub_bits <= (wr_data[2:0] > `SUB_BITS_MAX) ? `SUB_BITS_MAX : wr_data[2:0];
	end

	// ****************************************
	// pending and active state
	// ****************************************

	assign entry_mask = core_cmd.entry ? id_onehot(core_cmd.id) : '0;
	assign exit_mask = core_cmd.exit ? id_onehot(core_cmd.id) : '0;
	// core stacks its own state, so entry and return are single-cycle strobes
	assign next_active = (active | entry_mask) & ~exit_mask;

	// a held level re-pends once the interrupt is no longer active
	assign hw_set = (in_level & ~next_active) | in_rise;

	// sets win over clears; writing one to a pending bit leaves it pending
	assign next_pending = (((pending & ~sw_pending_clear & ~entry_mask) | sw_pending_set) | hw_set)
		& `IMPL_MASK;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pending <= `BANK_RESET;
		else if (do_write)
			pending <= next_pending;
		else
			pending <= (((pending & ~entry_mask) | hw_set)) & `IMPL_MASK;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			active <= `BANK_RESET;
		else
			active <= next_active & `IMPL_MASK;
	end

	// ****************************************
	// arbitration
	// ****************************************

	// strict compare keeps the lowest number on equal priority
	always_comb
	begin
		best_found = 1'b0;
		best_id = '0;
		best_prio = 4'hF;
		any_active = 1'b0;
		run_group = 4'hF;
		for (int n = 0; n < `NUM_IRQ; n++)
		begin
			if (pending[n] && enable[n] && !active[n] && (!best_found || prio[n] < best_prio))
			begin
				best_found = 1'b1;
				best_id = irq_id_t'(n);
				best_prio = prio[n];
			end
			if (active[n] && (!any_active || group_of(prio[n], sub_bits) < run_group))
			begin
				any_active = 1'b1;
				run_group = group_of(prio[n], sub_bits);
			end
		end
	end

	// only a strictly more urgent group preempts what runs
	assign preempt = best_found && (!any_active || group_of(best_prio, sub_bits) < run_group);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			core_req <= '0;
			nmi_req <= 1'b0;
		end
		else
		begin
			core_req.valid <= preempt && !core_cmd.entry;
			core_req.id <= best_id;
			core_req.prio <= best_prio;
			nmi_req <= nmi_pending && !core_cmd.nmi_ack;
		end
	end

	// ****************************************
	// register bus read decode
	// ****************************************

	always_comb
	begin
		logic [9:0] idx;
		idx = axi_in.araddr[11:2];
		rd_word = 32'h0000_0000;
		rd_mapped = (axi_in.araddr[31:12] == 20'h0_0000);
		if (idx >= `ENABLE_SET_BASE && idx < `ENABLE_SET_BASE + 10'(`NUM_WORDS))
			rd_word = enable[32*(idx - `ENABLE_SET_BASE) +: 32];
		else if (idx >= `ENABLE_CLEAR_BASE && idx < `ENABLE_CLEAR_BASE + 10'(`NUM_WORDS))
			rd_word = enable[32*(idx - `ENABLE_CLEAR_BASE) +: 32];
		else if (idx >= `PENDING_SET_BASE && idx < `PENDING_SET_BASE + 10'(`NUM_WORDS))
			rd_word = pending[32*(idx - `PENDING_SET_BASE) +: 32];
		else if (idx >= `PENDING_CLEAR_BASE && idx < `PENDING_CLEAR_BASE + 10'(`NUM_WORDS))
			rd_word = pending[32*(idx - `PENDING_CLEAR_BASE) +: 32];
		else if (idx >= `ACTIVE_FLAG_BASE && idx < `ACTIVE_FLAG_BASE + 10'(`NUM_WORDS))
			rd_word = active[32*(idx - `ACTIVE_FLAG_BASE) +: 32];
		else if (idx >= `PRIORITY_BASE && idx < `PRIORITY_BASE + 10'(`NUM_PRIO_WORDS))
		begin
			for (int b = 0; b < 4; b++)
				if (4 * int'(idx - `PRIORITY_BASE) + b < `NUM_IRQ)
					rd_word[b*8 +: 8] = {prio[4 * int'(idx - `PRIORITY_BASE) + b], 4'h0};
		end
		else if (idx == `CONTROL_WORD)
			rd_word = {29'h0000_0000, sub_bits};
		else if (idx == `STATUS_WORD)
			rd_word = {15'h0000, nmi_pending, any_active, 3'h0, run_group, 1'b0, best_id};
		else
			rd_mapped = 1'b0;
		// addresses above the block alias low offsets, so their data must be hidden
		if (!rd_mapped)
			rd_word = 32'h0000_0000;
	end

	// ****************************************
	// AXI4-Lite slave
	// ****************************************

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			wr_index <= 10'h000;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
			axi_out.awready <= 1'b0;
			axi_out.wready <= 1'b0;
			axi_out.bvalid <= 1'b0;
			axi_out.bresp <= `RESP_OKAY;
		end
		else
		begin
			axi_out.awready <= !aw_full && !(axi_in.awvalid && axi_out.awready) && !axi_out.bvalid;
			axi_out.wready <= !w_full && !(axi_in.wvalid && axi_out.wready) && !axi_out.bvalid;
			if (axi_in.awvalid && axi_out.awready)
			begin
				aw_full <= 1'b1;
				// addresses above the block map to no register
				wr_index <= (axi_in.awaddr[31:12] == 20'h0_0000) ? axi_in.awaddr[11:2] : 10'h3FF;
			end
			if (axi_in.wvalid && axi_out.wready)
			begin
				w_full <= 1'b1;
				wr_data <= axi_in.wdata;
				wr_strb <= axi_in.wstrb;
			end
			if (do_write)
			begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				axi_out.bvalid <= 1'b1;
				axi_out.bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (axi_out.bvalid && axi_in.bready)
				axi_out.bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			axi_out.arready <= 1'b0;
			axi_out.rvalid <= 1'b0;
			axi_out.rdata <= 32'h0000_0000;
			axi_out.rresp <= `RESP_OKAY;
		end
		else if (axi_in.arvalid && axi_out.arready)
		begin
			axi_out.arready <= 1'b0;
			axi_out.rvalid <= 1'b1;
			axi_out.rdata <= rd_word;
			axi_out.rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (axi_out.rvalid)
		begin
			if (axi_in.rready)
				axi_out.rvalid <= 1'b0;
		end
		else
			axi_out.arready <= 1'b1;
	end

endmodule

// >>> src/nested_irq_pkg.sv
// types shared by the interrupt enable and pending block
package nested_irq_pkg;

	typedef logic [3:0] prio_t;
	typedef logic [6:0] irq_id_t;

	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} axi_in_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axi_out_s;

	typedef struct packed {
		logic valid;
		irq_id_t id;
		prio_t prio;
	} core_req_s;

	typedef struct packed {
		logic entry;
		logic exit;
		irq_id_t id;
		logic nmi_ack;
	} core_cmd_s;

endpackage

// >>> src/nested_irq_regs.svh
// register offsets, field positions and reset values of the interrupt enable and pending block
// Summary of operation
// - up to 81 peripheral interrupt inputs accepted
// - priority 0 to 15, zero most urgent
// - requests detected as levels and as pulses
// - priority split into group and subpriority
// - priorities rewritable live, used by later arbitration
// - one external non-maskable input besides peripherals
// - core stacks and unstacks state by hardware
// - each bit bank spans three 32-bit words
// - one 8-bit priority field per interrupt
// - set-enable write one enables, reads enabled state
// - pending and enabled interrupts activate by priority
// - disabled interrupts pend but never activate
// - clear-enable write one disables, reads enabled state
// - set-pending write one makes interrupt pending
// - set-pending on pending interrupt changes nothing
// - set-pending on disabled interrupt still pends
// - enable and pending banks reset to zero
// - service entry clears pending, marks active
// - level still high at return pends again
`ifndef NESTED_IRQ_REGS_SVH
`define NESTED_IRQ_REGS_SVH

`define NUM_IRQ 81
`define NUM_WORDS 3
`define BANK_BITS 96
`define IMPL_MASK 96'h0001_FFFF_FFFF_FFFF_FFFF_FFFF
`define NUM_PRIO_WORDS 21

// word indices (byte address divided by four)
`define ENABLE_SET_BASE 10'h000
`define ENABLE_CLEAR_BASE 10'h020
`define PENDING_SET_BASE 10'h040
`define PENDING_CLEAR_BASE 10'h060
`define ACTIVE_FLAG_BASE 10'h080
`define PRIORITY_BASE 10'h0C0
`define CONTROL_WORD 10'h100
`define STATUS_WORD 10'h101

`define BANK_RESET 96'h0000_0000_0000_0000_0000_0000
`define CONTROL_RESET 3'h0
`define SUB_BITS_MAX 3'h4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif
